// ---- rtl/rpm_params.svh ----
// constants for the reference-input predivide and monitor block
`ifndef RPM_PARAMS_SVH
`define RPM_PARAMS_SVH

`define RPM_NUM_IN          14
`define RPM_NUM_CMP         2
`define RPM_NUM_DPLL        3
`define RPM_CLK_NS          10
`define RPM_LOS_TIME_US     1000
`define RPM_LOS_CYCLES      ((`RPM_LOS_TIME_US * 1000) / `RPM_CLK_NS)
`define RPM_EVAL_TIME_MS    128
`define RPM_EVAL_CYCLES     ((`RPM_EVAL_TIME_MS * 1000000) / `RPM_CLK_NS)
`define RPM_DRIFT_PPM       500
`define RPM_FREQ_8K         4'h0
`define RPM_FREQ_T1E1       4'h1
`define RPM_FREQ_6M48       4'h2
`define RPM_FREQ_2K         4'h9
`define RPM_FREQ_4K         4'ha
`define RPM_FREQ_PPS        4'hb
`define RPM_FREQ_6M25       4'hc
`define RPM_HF_BYPASS       2'h0
`define RPM_HF_DIV4         2'h1
`define RPM_HF_DIV5         2'h2
`define RPM_HF_FIRST        2
`define RPM_HF_LAST         7
`define RPM_DECAY0          8'h01
`define RPM_DECAY1          8'h02
`define RPM_DECAY2          8'h04
`define RPM_DECAY3          8'h08

`endif

// ---- rtl/rpm_pkg.sv ----
// types for the reference-input predivide and monitor block
package rpm_pkg;
    typedef logic [3:0]  rpm_code_t;
    typedef logic [14:0] rpm_integer_divider_t;
    typedef logic [15:0] rpm_frac_t;
    typedef enum logic [1:0] {
        RPM_WR_IDLE = 2'b00,
        RPM_WR_LOW  = 2'b01
    } rpm_integer_divider_wr_e;
endpackage

// ---- rtl/rpm_leaky_bucket.sv ----
// leaky-bucket activity accumulator for one reference input
`timescale 1ns/1ps
`default_nettype none
`include "rpm_params.svh"
module rpm_leaky_bucket
    import rpm_pkg::*;
(
    // clock and reset
    input  wire logic       mclk,
    input  wire logic       rst_n,
    // evaluation tick and event
    input  wire logic       evalTick,
    input  wire logic       driftEvent,
    // selected configuration
    input  wire logic [7:0] bucketSize,
    input  wire logic [7:0] upperThr,
    input  wire logic [7:0] lowerThr,
    input  wire logic [1:0] decayCode,
    // status
    output logic      [7:0] level,
    output logic            inactiveAlarm
);
    logic [7:0] level_q;
    logic [7:0] decayCnt_q;
    logic [7:0] decayLen;
    logic       alarm_q;

    always_comb begin
        case (decayCode)
            2'h0:    decayLen = `RPM_DECAY0;
            2'h1:    decayLen = `RPM_DECAY1;
            2'h2:    decayLen = `RPM_DECAY2;
            default: decayLen = `RPM_DECAY3;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            level_q    <= 8'h00;
            decayCnt_q <= 8'h00;
        end else if (evalTick) begin
            if (driftEvent) begin
                decayCnt_q <= 8'h00;
                // stop counting at the bucket size
                if (level_q < bucketSize) begin
                    level_q <= level_q + 8'h01;
                end
            end else if (decayCnt_q + 8'h01 >= decayLen) begin
                decayCnt_q <= 8'h00;
                if (level_q != 8'h00) begin
                    level_q <= level_q - 8'h01;
                end
            end else begin
                decayCnt_q <= decayCnt_q + 8'h01;
            end
        end
    end

    // hysteresis between the two thresholds
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            alarm_q <= 1'b0;
        end else if (level_q > upperThr) begin
            alarm_q <= 1'b1;
        end else if (level_q < lowerThr) begin
            alarm_q <= 1'b0;
        end
    end

    assign level         = level_q;
    assign inactiveAlarm = alarm_q;
endmodule
`default_nettype wire

// ---- rtl/rpm_ref_input_monitor.sv ----
// reference-input predivide configuration, composite handling and quality monitor
// Summary of operation
// - composite inputs carry 64k+8k, optional 0.4k; select bit must match
// - flag composite violations; interrupt only when that violation mask bit set
// - each input has a 4-bit sync-source select choosing its frame pulse pin
// - composite inputs: required frequency forced 8 kHz, predivider bypassed
// - required-frequency code map; other codes reserved
// - inputs 3-8 high-frequency divider: divide 4, 5 or bypass
// - integer divider bypassed unless direct-divide or lock-to-8k bit set
// - integer divider divides by factor plus one
// - fractional divider uses 16-bit numerator over 16-bit denominator
// - loss monitoring on composites only; activity on all; qualified to three DPLLs
// - loss declared after 1 ms low amplitude, cleared on recovery
// - composite loss status bit, interrupt, and disqualification
// - per-input bucket every 128 ms: up on event, down per decay period
// - event is drift beyond 500 ppm within a 128 ms period
// - four bucket configurations, each input selects one by 2-bit field
// - accumulator saturates at bucket size
// - alarm above upper threshold, cleared below lower threshold
// - config: 8-bit size, upper, lower thresholds and 2-bit decay code
// - per-input inactive alarm bit disqualifies the input
// - severe frequency alarm disqualifies; soft alarm does not
`timescale 1ns/1ps
`default_nettype none
`include "rpm_params.svh"
module rpm_ref_input_monitor
    import rpm_pkg::*;
#(
    parameter int unsigned LOS_CYCLES  = `RPM_LOS_CYCLES,
    parameter int unsigned EVAL_CYCLES = `RPM_EVAL_CYCLES
) (
    // clock and reset
    input  wire logic        mclk,
    input  wire logic        rst_n,
    // composite input front end
    input  wire logic [1:0]  compositeLowTone,
    input  wire logic        composite_low_tone_select,
    input  wire logic [1:0]  compositeStructOk,
    input  wire logic [1:0]  ampLow,
    input  wire logic [1:0]  ampRecovered,
    input  wire logic [1:0]  violationMask,
    input  wire logic [1:0]  lossMask,
    // per-input configuration, flattened by input index
    input  wire logic [55:0] input_loss_sync_config,
    input  wire logic [55:0] reqFreqCode,
    input  wire logic [27:0] syncFreq,
    input  wire logic [27:0] high_freq_divide_select,
    input  wire logic [13:0] directDivide,
    input  wire logic [13:0] lock_to_eight_khz,
    input  wire logic [13:0] lineStandardSdh,
    input  wire logic [7:0]  divnWrData,
    input  wire logic [13:0] divnWrLow,
    input  wire logic [13:0] divnWrHigh,
    input  wire logic [223:0] fracNumerator,
    input  wire logic [223:0] fracDenominator,
    // leaky-bucket configurations
    input  wire logic [27:0] bucketSelect,
    input  wire logic [31:0] bucketSizeCfg,
    input  wire logic [31:0] upperThrCfg,
    input  wire logic [31:0] lowerThrCfg,
    input  wire logic [7:0]  decayRateCfg,
    // frequency measurement and alarms
    input  wire logic [223:0] driftPpm,
    input  wire logic [13:0] input_freq_severe_alarm,
    input  wire logic [13:0] freqSoftAlarm,
    // status and results
    output logic             composite1_violation_flag,
    output logic             composite2_violation_flag,
    output logic             composite1_signal_loss,
    output logic             composite2_signal_loss,
    output logic             intReq,
    output logic [13:0]      input_inactive_alarm,
    output logic [13:0]      inputQualified,
    output logic [41:0]      dpllQualified,
    output logic [55:0]      effFreqCode,
    output logic [13:0]      reservedCode,
    output logic [13:0]      hfBypassed,
    output logic [13:0]      divnBypassed,
    output logic [209:0]     integer_division_factor,
    output logic [13:0]      fracValid,
    output logic [55:0]      syncSource,
    output logic [27:0]      hfRatio
);
    logic [1:0]  viol_q;
    logic [1:0]  loss_q;
    logic [1:0]  lossAct;
    logic [19:0] lowCnt_q [2];
    logic        intReq_q;
    logic [31:0] evalCnt_q;
    logic        evalTick_q;
    logic [13:0] alarm;
    logic [13:0] qual_q;
    logic [41:0] dpllQual_q;
    logic [55:0] freq_q;
    logic [13:0] resv_q;
    logic [13:0] hfByp_q;
    logic [13:0] divnByp_q;
    logic [14:0] integer_divider_q [14];
    logic [7:0]  divnLow_q [14];
    rpm_integer_divider_wr_e wrState_q [14];
    logic [13:0] frac_q;
    logic [55:0] sync_q;
    logic [27:0] hf_q;
    logic [13:0] lowToneMismatch;

    localparam logic [19:0] LosLast  = 20'(LOS_CYCLES - 1);
    localparam logic [31:0] EvalLast = 32'(EVAL_CYCLES - 1);

    // composite front end
    always_comb begin
        for (int c = 0; c < `RPM_NUM_CMP; c++) begin
            // a low tone present/absent against the select bit is a structure break
            lowToneMismatch[c] = compositeLowTone[c] ^ composite_low_tone_select;
            lossAct[c]         = loss_q[c];
        end
        lowToneMismatch[13:2] = 12'h000;
    end

    genvar gc;
    generate
        for (gc = 0; gc < `RPM_NUM_CMP; gc++) begin : g_cmp
            // violation flag is sticky while its mask bit is set so a short break is not missed
            always_ff @(posedge mclk) begin
                if (!rst_n) begin
                    viol_q[gc] <= 1'b0;
                end else if (!compositeStructOk[gc] || lowToneMismatch[gc]) begin
                    viol_q[gc] <= 1'b1;
                end else if (!violationMask[gc]) begin
                    viol_q[gc] <= 1'b0;
                end
            end

            always_ff @(posedge mclk) begin
                if (!rst_n) begin
                    lowCnt_q[gc] <= 20'h00000;
                    loss_q[gc]   <= 1'b0;
                end else if (ampRecovered[gc]) begin
                    lowCnt_q[gc] <= 20'h00000;
                    loss_q[gc]   <= 1'b0;
                end else if (ampLow[gc]) begin
                    if (lowCnt_q[gc] >= LosLast) begin
                        loss_q[gc] <= 1'b1;
                    end else begin
                        lowCnt_q[gc] <= lowCnt_q[gc] + 20'h00001;
                    end
                end else begin
                    lowCnt_q[gc] <= 20'h00000;
                end
            end
        end
    endgenerate

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            intReq_q <= 1'b0;
        end else begin
            intReq_q <= |(viol_q & violationMask) | |(loss_q & lossMask);
        end
    end

    // common 128 ms evaluation tick
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            evalCnt_q  <= 32'h00000000;
            evalTick_q <= 1'b0;
        end else if (evalCnt_q >= EvalLast) begin
            evalCnt_q  <= 32'h00000000;
            evalTick_q <= 1'b1;
        end else begin
            evalCnt_q  <= evalCnt_q + 32'h00000001;
            evalTick_q <= 1'b0;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < `RPM_NUM_IN; gi++) begin : g_in
            logic [1:0] sel;
            logic       drift;
            logic [3:0] code;
            assign sel   = bucketSelect[2*gi +: 2];
            // the monitor reports |drift| in ppm over the last period
            assign drift = driftPpm[16*gi +: 16] > 16'(`RPM_DRIFT_PPM);
            assign code  = reqFreqCode[4*gi +: 4];

            rpm_leaky_bucket u_bucket (
                .mclk          (mclk),
                .rst_n         (rst_n),
                .evalTick      (evalTick_q),
                .driftEvent    (drift),
                .bucketSize    (bucketSizeCfg[8*sel +: 8]),
                .upperThr      (upperThrCfg[8*sel +: 8]),
                .lowerThr      (lowerThrCfg[8*sel +: 8]),
                .decayCode     (decayRateCfg[2*sel +: 2]),
                .level         (),
                .inactiveAlarm (alarm[gi])
            );

            // qualification: soft alarm deliberately ignored
            always_ff @(posedge mclk) begin
                if (!rst_n) begin
                    qual_q[gi] <= 1'b0;
                    dpllQual_q[3*gi +: 3] <= 3'h0;
                end else begin
                    qual_q[gi] <= !alarm[gi] && !input_freq_severe_alarm[gi]
                        && !((gi < `RPM_NUM_CMP) && lossAct[gi & 1]);
                    dpllQual_q[3*gi +: 3] <= {3{qual_q[gi]}};
                end
            end

            // required frequency and divider path decode
            always_ff @(posedge mclk) begin
                if (!rst_n) begin
                    freq_q[4*gi +: 4] <= `RPM_FREQ_8K;
                    resv_q[gi]        <= 1'b0;
                    hfByp_q[gi]       <= 1'b1;
                    hf_q[2*gi +: 2]   <= 2'h0;
                    divnByp_q[gi]     <= 1'b1;
                    sync_q[4*gi +: 4] <= 4'h0;
                    frac_q[gi]        <= 1'b0;
                end else begin
                    sync_q[4*gi +: 4] <= input_loss_sync_config[4*gi +: 4];
                    frac_q[gi] <= fracDenominator[16*gi +: 16] != 16'h0000;
                    if (gi < `RPM_NUM_CMP) begin
                        freq_q[4*gi +: 4] <= `RPM_FREQ_8K;
                        resv_q[gi]        <= 1'b0;
                        hfByp_q[gi]       <= 1'b1;
                        hf_q[2*gi +: 2]   <= 2'h0;
                        divnByp_q[gi]     <= 1'b1;
                    end else begin
                        freq_q[4*gi +: 4] <= code;
                        case (code)
                            `RPM_FREQ_8K, `RPM_FREQ_T1E1, `RPM_FREQ_6M48, `RPM_FREQ_2K,
                            `RPM_FREQ_4K, `RPM_FREQ_PPS, `RPM_FREQ_6M25: resv_q[gi] <= 1'b0;
                            default: resv_q[gi] <= 1'b1;
                        endcase
                        if (gi >= `RPM_HF_FIRST && gi <= `RPM_HF_LAST) begin
                            case (high_freq_divide_select[2*gi +: 2])
                                `RPM_HF_DIV4: begin
                                    hfByp_q[gi]     <= 1'b0;
                                    hf_q[2*gi +: 2] <= 2'h1;
                                end
                                `RPM_HF_DIV5: begin
                                    hfByp_q[gi]     <= 1'b0;
                                    hf_q[2*gi +: 2] <= 2'h2;
                                end
                                default: begin
                                    hfByp_q[gi]     <= 1'b1;
                                    hf_q[2*gi +: 2] <= 2'h0;
                                end
                            endcase
                        end else begin
                            hfByp_q[gi]     <= 1'b1;
                            hf_q[2*gi +: 2] <= 2'h0;
                        end
                        // both bits clear means the integer stage is skipped
                        divnByp_q[gi] <= !(directDivide[gi] || lock_to_eight_khz[gi]);
                    end
                end
            end

            // two-step factor load; upper write commits the whole word after a low write, else only the upper bits
            always_ff @(posedge mclk) begin
                if (!rst_n) begin
                    integer_divider_q[gi]    <= 15'h0000;
                    divnLow_q[gi] <= 8'h00;
                    wrState_q[gi] <= RPM_WR_IDLE;
                end else if (divnWrLow[gi]) begin
                    divnLow_q[gi] <= divnWrData;
                    wrState_q[gi] <= RPM_WR_LOW;
                end else if (divnWrHigh[gi]) begin
                    case (wrState_q[gi])
                        RPM_WR_LOW: integer_divider_q[gi] <= {divnWrData[6:0], divnLow_q[gi]};
                        default:    integer_divider_q[gi] <= {divnWrData[6:0], integer_divider_q[gi][7:0]};
                    endcase
                    wrState_q[gi] <= RPM_WR_IDLE;
                end
            end
            // the divider counts factor+1 input edges per output
            assign integer_division_factor[15*gi +: 15] = integer_divider_q[gi];
        end
    endgenerate

    assign composite1_violation_flag = viol_q[0];
    assign composite2_violation_flag = viol_q[1];
    assign composite1_signal_loss    = loss_q[0];
    assign composite2_signal_loss    = loss_q[1];
    assign intReq                    = intReq_q;
    assign inputQualified            = qual_q;
    assign dpllQualified             = dpllQual_q;
    assign effFreqCode               = freq_q;
    assign reservedCode              = resv_q;
    assign hfBypassed                = hfByp_q;
    assign divnBypassed              = divnByp_q;
    assign fracValid                 = frac_q;
    assign syncSource                = sync_q;
    assign hfRatio                   = hf_q;

    // alarms registered in the bucket module
    assign input_inactive_alarm = alarm;
endmodule
`default_nettype wire

// ---- test/rpm_mon_assertions.sv ----
// port assertions for the reference-input monitor
`timescale 1ns/1ps
`default_nettype none
module rpm_mon_chk (
    // watched inputs
    input wire logic         mclk,
    input wire logic         rst_n,
    input wire logic [1:0]   compositeStructOk,
    input wire logic [1:0]   ampRecovered,
    input wire logic [1:0]   violationMask,
    input wire logic [1:0]   lossMask,
    input wire logic [55:0]  reqFreqCode,
    input wire logic [27:0]  high_freq_divide_select,
    input wire logic [13:0]  directDivide,
    input wire logic [13:0]  lock_to_eight_khz,
    input wire logic [7:0]   divnWrData,
    input wire logic [13:0]  divnWrLow,
    input wire logic [13:0]  divnWrHigh,
    input wire logic [13:0]  input_freq_severe_alarm,
    // watched outputs
    input wire logic         composite1_violation_flag,
    input wire logic         composite2_violation_flag,
    input wire logic         composite1_signal_loss,
    input wire logic         composite2_signal_loss,
    input wire logic         intReq,
    input wire logic [13:0]  inputQualified,
    input wire logic [41:0]  dpllQualified,
    input wire logic [55:0]  effFreqCode,
    input wire logic [13:0]  reservedCode,
    input wire logic [13:0]  hfBypassed,
    input wire logic [13:0]  divnBypassed,
    input wire logic [209:0] integer_division_factor
);
    logic resvIn3;
    logic hfOnIn3;
    logic anyIrq;
    assign resvIn3 = !(reqFreqCode[11:8] inside {4'h0, 4'h1, 4'h2, 4'h9, 4'ha, 4'hb, 4'hc});
    assign hfOnIn3 = high_freq_divide_select[5:4] inside {2'h1, 2'h2};
    assign anyIrq = |({composite2_violation_flag, composite1_violation_flag} & violationMask)
        | |({composite2_signal_loss, composite1_signal_loss} & lossMask);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    viol_set_a: assert property (!compositeStructOk[0] |=> composite1_violation_flag)
        else $error("violation flag not raised");
    int_gate_a: assert property (!anyIrq |=> !intReq)
        else $error("stray interrupt");
    comp_fixed_a: assert property (effFreqCode[7:0] == 8'h00 && divnBypassed[1:0] == 2'h3)
        else $error("composite not fixed");
    resv_code_a: assert property (##1 reservedCode[2] == $past(resvIn3))
        else $error("reserved code flag wrong");
    hf_select_a: assert property (##1 hfBypassed[2] == !$past(hfOnIn3))
        else $error("high divider bypass wrong");
    integer_divider_bypass_a: assert property (!directDivide[2] && !lock_to_eight_khz[2] |=> divnBypassed[2])
        else $error("integer divider not bypassed");
    factor_load_a: assert property (divnWrLow[2] ##1 (divnWrHigh[2] && !divnWrLow[2]) |=>
        integer_division_factor[44:30] == {$past(divnWrData[6:0]), $past(divnWrData, 2)})
        else $error("division factor not committed");
    loss_clear_a: assert property (ampRecovered[0] |=> !composite1_signal_loss)
        else $error("loss not cleared on recovery");
    severe_disq_a: assert property (input_freq_severe_alarm[5] [*2] |=> !inputQualified[5])
        else $error("severe input qualified");
    dpll_disq_a: assert property (!inputQualified[4] |=> dpllQualified[14:12] == 3'h0)
        else $error("disqualified input offered");

    cover property (composite1_signal_loss);
    cover property (intReq);
    cover property (!inputQualified[4] ##1 inputQualified[4]);
endmodule
bind rpm_ref_input_monitor rpm_mon_chk rpm_mon_chk_inst (.*);
`default_nettype wire

// ---- test/rpm_ref_src.sv ----
// behavioural model of the reference sources feeding the monitor
`timescale 1ns/1ps
`default_nettype none
module rpm_ref_src (
    // clock and scenario controls
    input wire logic     mclk,
    input wire logic [1:0]  lossOn,
    input wire logic [1:0]  badFrame,
    input wire logic [1:0]  toneOn,
    input wire logic [13:0] driftOn,
    // what the monitor sees
    output logic [1:0]   ampLow,
    output logic [1:0]   ampRecovered,
    output logic [1:0]   compositeStructOk,
    output logic [1:0]   compositeLowTone,
    output logic [223:0] driftPpm
);
    initial begin
        ampLow = 2'h0;
        ampRecovered = 2'h3;
        compositeStructOk = 2'h3;
        compositeLowTone = 2'h0;
        driftPpm = '0;
        forever begin
            @(posedge mclk);
            ampLow <= lossOn;
            ampRecovered <= ~lossOn;
            compositeStructOk <= ~badFrame;
            compositeLowTone <= toneOn;
            // at the limit and one ppm above it, so an off-by-one compare shows
            for (int i = 0; i < 14; i++) begin
                driftPpm[16*i+:16] <= driftOn[i] ? 16'h01f5 : 16'h01f4;
            end
        end
    end
endmodule
`default_nettype wire

// ---- test/tb.sv ----
// self-checking bench for the reference-input monitor
`timescale 1ns/1ps
`default_nettype none
module tb;
    localparam int unsigned EVAL = 20;
    logic         mclk, rst_n, composite_low_tone_select, intReq;
    logic         composite1_violation_flag, composite2_violation_flag;
    logic         composite1_signal_loss, composite2_signal_loss;
    logic [1:0]   compositeLowTone, compositeStructOk, ampLow, ampRecovered;
    logic [1:0]   violationMask, lossMask, lossOn, badFrame, toneOn;
    logic [7:0]   divnWrData, decayRateCfg;
    logic [13:0]  directDivide, lock_to_eight_khz, lineStandardSdh, divnWrLow, divnWrHigh;
    logic [13:0]  input_freq_severe_alarm, freqSoftAlarm, input_inactive_alarm, driftOn;
    logic [13:0]  inputQualified, reservedCode, hfBypassed, divnBypassed, fracValid;
    logic [27:0]  syncFreq, high_freq_divide_select, bucketSelect, hfRatio;
    logic [31:0]  bucketSizeCfg, upperThrCfg, lowerThrCfg;
    logic [41:0]  dpllQualified;
    logic [55:0]  input_loss_sync_config, reqFreqCode, effFreqCode, syncSource;
    logic [209:0] integer_division_factor;
    logic [223:0] fracNumerator, fracDenominator, driftPpm;
    int           errorCnt, nTests;

    rpm_ref_input_monitor #(.LOS_CYCLES(10), .EVAL_CYCLES(EVAL))
        rpm_ref_input_monitor_inst (.*);
    rpm_ref_src rpm_ref_src_inst (.*);

    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    task automatic chkb(input string nm, input logic e, input logic g);
        nTests++;
        if (g !== e) begin
            errorCnt++;
            $display("unexpected %s: expected %b seen %b", nm, e, g);
        end
    endtask
    task automatic chkv(input string nm, input logic [15:0] e, input logic [15:0] g);
        nTests++;
        if (g !== e) begin
            errorCnt++;
            $display("unexpected %s: expected %h seen %h", nm, e, g);
        end
    endtask
    // low byte then upper bits; withLow low skips the first
    task automatic wrFactor(input logic [7:0] lo, input logic [7:0] hi, input logic withLow);
        @(posedge mclk);
        divnWrData <= lo;
        divnWrLow[2] <= withLow;
        @(posedge mclk);
        divnWrLow[2] <= 1'b0;
        divnWrHigh[2] <= 1'b1;
        divnWrData <= hi;
        @(posedge mclk);
        divnWrHigh[2] <= 1'b0;
    endtask
    task automatic results();
        $display("comparisons %0d mismatches %0d", nTests, errorCnt);
        if (errorCnt == 0 && nTests > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    initial begin
        repeat (5000) @(posedge mclk);
        errorCnt++;
        results();
    end

    initial begin
        rst_n = 1'b0;
        composite_low_tone_select = 1'b0;
        {violationMask, lossMask, lossOn, badFrame, toneOn} = '0;
        {divnWrData, decayRateCfg, directDivide, lock_to_eight_khz, lineStandardSdh} = '0;
        {divnWrLow, divnWrHigh, input_freq_severe_alarm, freqSoftAlarm, driftOn} = '0;
        {syncFreq, high_freq_divide_select, bucketSelect, bucketSizeCfg} = '0;
        {upperThrCfg, lowerThrCfg, input_loss_sync_config, reqFreqCode} = '0;
        {fracNumerator, fracDenominator} = '0;
        fracDenominator[47:32] = 16'h0003;
        errorCnt = 0;
        nTests = 0;
        cyc(11);
        chkv("hfBypassed", 16'h3fff, {2'b00, hfBypassed});
        chkv("divnBypassed", 16'h3fff, {2'b00, divnBypassed});
        @(posedge mclk);
        rst_n <= 1'b1;
        for (int c = 0; c < 16; c++) begin
            @(posedge mclk);
            reqFreqCode[11:8] <= c[3:0];
            reqFreqCode[3:0] <= c[3:0];
            input_loss_sync_config[11:8] <= c[3:0];
            cyc(2);
            chkb("reservedCode", !(c inside {0, 1, 2, 9, 10, 11, 12}), reservedCode[2]);
            chkv("effFreqCode", 16'h0000, {8'h00, effFreqCode[7:0]});
            chkv("syncSource", {12'h000, c[3:0]}, {12'h000, syncSource[11:8]});
        end
        for (int s = 0; s < 4; s++) begin
            @(posedge mclk);
            high_freq_divide_select[5:4] <= s[1:0];
            cyc(2);
            chkb("hfBypassed", s == 0 || s == 3, hfBypassed[2]);
            chkv("hfRatio", (s == 3) ? 16'h0 : 16'(s), {14'h0, hfRatio[5:4]});
        end
        chkv("fracValid", 16'h0004, {2'b00, fracValid});
        @(posedge mclk);
        directDivide[2] <= 1'b1;
        cyc(2);
        chkb("divnBypassed", 1'b0, divnBypassed[2]);
        @(posedge mclk);
        directDivide[2] <= 1'b0;
        lock_to_eight_khz[2] <= 1'b1;
        cyc(2);
        chkb("divnBypassed", 1'b0, divnBypassed[2]);
        @(posedge mclk);
        lock_to_eight_khz[2] <= 1'b0;
        cyc(2);
        chkb("divnBypassed", 1'b1, divnBypassed[2]);
        wrFactor(8'h34, 8'h12, 1'b1);
        cyc(2);
        chkv("factor", 16'h1234, {1'b0, integer_division_factor[44:30]});
        wrFactor(8'hff, 8'h05, 1'b0);
        cyc(2);
        chkv("factor", 16'h0534, {1'b0, integer_division_factor[44:30]});
        // masked violation sticks until the mask is cleared
        @(posedge mclk);
        violationMask <= 2'b01;
        badFrame <= 2'b01;
        @(posedge mclk);
        badFrame <= 2'b00;
        cyc(5);
        chkb("violation1", 1'b1, composite1_violation_flag);
        chkb("intReq", 1'b1, intReq);
        @(posedge mclk);
        violationMask <= 2'b00;
        badFrame <= 2'b10;
        cyc(4);
        chkb("violation1", 1'b0, composite1_violation_flag);
        chkb("violation2", 1'b1, composite2_violation_flag);
        chkb("intReq", 1'b0, intReq);
        @(posedge mclk);
        badFrame <= 2'b00;
        composite_low_tone_select <= 1'b1;
        toneOn <= 2'b01;
        cyc(4);
        chkb("violation1", 1'b0, composite1_violation_flag);
        chkb("violation2", 1'b1, composite2_violation_flag);
        @(posedge mclk);
        toneOn <= 2'b11;
        lossOn <= 2'b01;
        lossMask <= 2'b01;
        cyc(6);
        chkb("violation2", 1'b0, composite2_violation_flag);
        chkb("loss1", 1'b0, composite1_signal_loss);
        cyc(10);
        chkb("loss1", 1'b1, composite1_signal_loss);
        chkb("loss2", 1'b0, composite2_signal_loss);
        chkb("intReq", 1'b1, intReq);
        chkb("qualified1", 1'b0, inputQualified[0]);
        @(posedge mclk);
        lossOn <= 2'b00;
        lossMask <= 2'b00;
        cyc(3);
        chkb("loss1", 1'b0, composite1_signal_loss);
        // input 5 uses set 1; set 0 never alarms, so a wrong select shows
        @(posedge mclk);
        bucketSelect[9:8] <= 2'h1;
        bucketSizeCfg <= 32'h0000_03ff;
        upperThrCfg <= 32'h0000_02ff;
        lowerThrCfg <= 32'h0000_0200;
        decayRateCfg <= 8'h03;
        driftOn[4] <= 1'b1;
        cyc(12 * EVAL);
        chkb("inactive5", 1'b1, input_inactive_alarm[4]);
        chkb("qualified5", 1'b0, inputQualified[4]);
        chkv("dpll5", 16'h0000, {13'h0000, dpllQualified[14:12]});
        @(posedge mclk);
        driftOn[4] <= 1'b0;
        // an unsaturated bucket would still alarm here
        cyc(3 * EVAL + 5);
        chkb("inactive5", 1'b0, input_inactive_alarm[4]);
        chkv("dpll5", 16'h0007, {13'h0000, dpllQualified[14:12]});
        @(posedge mclk);
        freqSoftAlarm[5] <= 1'b1;
        cyc(4);
        chkb("qualified6", 1'b1, inputQualified[5]);
        @(posedge mclk);
        input_freq_severe_alarm[5] <= 1'b1;
        cyc(4);
        chkb("qualified6", 1'b0, inputQualified[5]);
        results();
    end
endmodule
`default_nettype wire
